// file: hoist_brake_pkg.sv
/*
 * Shared constants and types for the hoist brake signal control block.
 * Assumes current in 0.1 A units, frequency in 0.1 Hz units, times in 0.1 s units.
 */
package hoist_brake_pkg;

    // ------------------------------------------------------------
    // Value widths
    // ------------------------------------------------------------
    localparam int CUR_W = 16;              // Output current, 0.1 A units
    localparam int FREQ_W = 16;             // Output frequency, 0.1 Hz units
    localparam int PCT_W = 8;               // Current threshold, percent
    localparam int HOLD_W = 6;              // Hold time, 0.1 s units
    localparam int MODEL_W = 2;             // Low-voltage model index
    localparam int PROD_W = 24;             // Width of threshold products

    // ------------------------------------------------------------
    // Setting ranges
    // ------------------------------------------------------------
    localparam logic [PCT_W-1:0] PCT_MAX = 8'hc8;        // 200 percent
    localparam logic [FREQ_W-1:0] FREQ_THR_MAX = 16'h00fa; // 25.0 Hz
    localparam logic [HOLD_W-1:0] HOLD_MAX = 6'h32;      // 5.0 s
    localparam logic [PROD_W-1:0] PERCENT_SCALE = 24'h000064; // 100 percent

    // ------------------------------------------------------------
    // Reference currents of the low-voltage variants, 0.1 A units
    // ------------------------------------------------------------
    localparam logic [CUR_W-1:0] REF_CUR_0 = 16'h0008;  // 0.8 A
    localparam logic [CUR_W-1:0] REF_CUR_1 = 16'h000f;  // 1.5 A
    localparam logic [CUR_W-1:0] REF_CUR_2 = 16'h001e;  // 3.0 A
    localparam logic [CUR_W-1:0] REF_CUR_3 = 16'h0032;  // 5.0 A

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;           // 40 MHz control clock
    localparam int TIME_STEP_NS = 100_000_000;   // One hold-time step, 0.1 s
    localparam int STEP_CYCLES = TIME_STEP_NS / CLK_PERIOD_NS;

    // Pin input index within the synchroniser vector
    localparam int PIN_RUN = 0;
    localparam int PIN_MOTOR2 = 1;
    localparam int PIN_COAST = 2;
    localparam int PIN_ALARM = 3;
    localparam int PIN_N = 4;

    // ------------------------------------------------------------
    // Brake state
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        BRAKE_APPLIED = 1'b0,
        BRAKE_RELEASED = 1'b1
    } brake_state_t;

endpackage

// file: brake_hold_timer.sv
/*
 * Continuous-qualification hold timer for the brake control.
 * Assumes qual_in and hold_in come from logic on the same clock.
 */
module brake_hold_timer #(
    parameter int STEP_CYCLES = hoist_brake_pkg::STEP_CYCLES
) (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic qual_in,
    input wire logic [hoist_brake_pkg::HOLD_W-1:0] hold_in,
    output logic done_out
);

    // ------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------
    logic [31:0] cycle_cnt;                         // Cycles within one step
    logic [hoist_brake_pkg::HOLD_W-1:0] step_cnt;   // Whole steps qualified
    logic step_end;                                  // Last cycle of a step
    logic reached;                                   // Hold time covered

    assign step_end = (cycle_cnt == 32'(STEP_CYCLES - 1));
    assign reached = (step_cnt >= hold_in);

    // Count saturates once reached, so long holds never wrap
    // R7: restart when qualification drops
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cycle_cnt <= 32'h0000_0000;
            step_cnt <= '0;
        end else if (!qual_in) begin
            cycle_cnt <= 32'h0000_0000;
            step_cnt <= '0;
        end else if (!reached) begin
            // Counting a step
            cycle_cnt <= step_end ? 32'h0000_0000 : cycle_cnt + 32'h0000_0001;
            if (step_end) begin
                step_cnt <= step_cnt + hoist_brake_pkg::HOLD_W'(1);
            end
        end
    end

    // Done only while qualification still holds
    assign done_out = qual_in && reached;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_TIMER_RESTART: // R7
        assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
            !qual_in |=> (step_cnt == '0) && (cycle_cnt == 32'h0000_0000))
        else $error("hold timer did not restart after qualification dropped");

    AST_TIMER_NO_EARLY: // R1
        assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
            $rose(qual_in) && (hold_in != '0) |-> !done_out)
        else $error("hold timer finished on the first qualified cycle");

endmodule

// file: hoist_brake_signal_control.sv
/*
 * Brake release signal control for a hoisting motor drive.
 * Assumes current and frequency samples come from drive logic on sys_clk_in,
 * and run, motor select, coast and alarm levels come from pins.
 */
// Operation
// R1: Release after current or frequency held above threshold
// R2: Current threshold percent of rated or reference
// R3: Apply after run off and frequency held low
// R4: Second motor selected keeps brake released
// R5: Alarm or coast stop forces output immediately
// R6: High output releases brake, low applies it
// R7: Hold timers restart when qualification drops
module hoist_brake_signal_control #(
    parameter int STEP_CYCLES = hoist_brake_pkg::STEP_CYCLES
) (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    // Drive measurements
    input wire logic [hoist_brake_pkg::CUR_W-1:0] output_current_in,
    input wire logic [hoist_brake_pkg::FREQ_W-1:0] output_frequency_in,
    input wire logic [hoist_brake_pkg::CUR_W-1:0] rated_current_in,
    // Variant straps
    input wire logic low_voltage_variant_in,
    input wire logic [hoist_brake_pkg::MODEL_W-1:0] model_index_in,
    // Brake settings
    input wire logic [hoist_brake_pkg::PCT_W-1:0] release_current_threshold_in,
    input wire logic [hoist_brake_pkg::FREQ_W-1:0] release_frequency_threshold_in,
    input wire logic [hoist_brake_pkg::HOLD_W-1:0] release_hold_time_in,
    input wire logic [hoist_brake_pkg::FREQ_W-1:0] apply_frequency_threshold_in,
    input wire logic [hoist_brake_pkg::HOLD_W-1:0] apply_hold_time_in,
    // Pin-level commands
    input wire logic run_command_in,
    input wire logic second_motor_select_in,
    input wire logic coast_stop_command_in,
    input wire logic alarm_shutdown_in,
    // Brake actuator drive
    output logic brake_release_output_out
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [hoist_brake_pkg::PIN_N-1:0] pin_raw;    // Raw pin levels
    logic [hoist_brake_pkg::PIN_N-1:0] pin_meta;   // First stage, read only by second
    logic [hoist_brake_pkg::PIN_N-1:0] pin_sync;   // Safe to use

    assign pin_raw[hoist_brake_pkg::PIN_RUN] = run_command_in;
    assign pin_raw[hoist_brake_pkg::PIN_MOTOR2] = second_motor_select_in;
    assign pin_raw[hoist_brake_pkg::PIN_COAST] = coast_stop_command_in;
    assign pin_raw[hoist_brake_pkg::PIN_ALARM] = alarm_shutdown_in;

    // Two flops per pin
    generate
        for (genvar i = 0; i < hoist_brake_pkg::PIN_N; i++) begin : g_sync
            always_ff @(posedge sys_clk_in or negedge resetn_in) begin
                if (!resetn_in) begin
                    pin_meta[i] <= 1'b0;
                    pin_sync[i] <= 1'b0;
                end else begin
                    pin_meta[i] <= pin_raw[i];
                    pin_sync[i] <= pin_meta[i];
                end
            end
        end
    endgenerate

    logic run_on;        // Run command active
    logic motor2_sel;    // Second motor selected
    logic shutdown;      // Alarm or coast stop in force
    logic forced;        // Timers bypassed

    assign run_on = pin_sync[hoist_brake_pkg::PIN_RUN];
    assign motor2_sel = pin_sync[hoist_brake_pkg::PIN_MOTOR2];
    assign shutdown = pin_sync[hoist_brake_pkg::PIN_COAST] | pin_sync[hoist_brake_pkg::PIN_ALARM];
    assign forced = shutdown | motor2_sel;

    // ------------------------------------------------------------
    // Current basis selection
    // ------------------------------------------------------------
    logic [hoist_brake_pkg::CUR_W-1:0] ref_current;  // Per-model reference
    logic [hoist_brake_pkg::CUR_W-1:0] basis;        // 100 percent current

    // Low-voltage single-phase models use a fixed reference
    assign ref_current = (model_index_in == 2'h0) ? hoist_brake_pkg::REF_CUR_0 :
                         (model_index_in == 2'h1) ? hoist_brake_pkg::REF_CUR_1 :
                         (model_index_in == 2'h2) ? hoist_brake_pkg::REF_CUR_2 :
                                                    hoist_brake_pkg::REF_CUR_3;

    // R2: pick percentage basis
    assign basis = low_voltage_variant_in ? ref_current : rated_current_in;

    // ------------------------------------------------------------
    // Threshold comparisons
    // ------------------------------------------------------------
    logic [hoist_brake_pkg::PCT_W-1:0] pct_clamped;   // Threshold within range
    logic [hoist_brake_pkg::PROD_W-1:0] cur_scaled;   // Current times 100
    logic [hoist_brake_pkg::PROD_W-1:0] thr_scaled;   // Percent times basis
    logic [hoist_brake_pkg::FREQ_W-1:0] rel_freq_thr; // Clamped release frequency
    logic [hoist_brake_pkg::FREQ_W-1:0] app_freq_thr; // Clamped apply frequency
    logic [hoist_brake_pkg::HOLD_W-1:0] rel_hold;     // Clamped release hold
    logic [hoist_brake_pkg::HOLD_W-1:0] app_hold;     // Clamped apply hold
    logic cur_over;                                   // Current above threshold
    logic freq_over;                                  // Frequency above threshold
    logic freq_low;                                   // Frequency below apply level

    // Out-of-range settings clamp to the top of their range
    assign pct_clamped = (release_current_threshold_in > hoist_brake_pkg::PCT_MAX) ?
                         hoist_brake_pkg::PCT_MAX : release_current_threshold_in;
    assign rel_freq_thr = (release_frequency_threshold_in > hoist_brake_pkg::FREQ_THR_MAX) ?
                          hoist_brake_pkg::FREQ_THR_MAX : release_frequency_threshold_in;
    assign app_freq_thr = (apply_frequency_threshold_in > hoist_brake_pkg::FREQ_THR_MAX) ?
                          hoist_brake_pkg::FREQ_THR_MAX : apply_frequency_threshold_in;
    assign rel_hold = (release_hold_time_in > hoist_brake_pkg::HOLD_MAX) ?
                      hoist_brake_pkg::HOLD_MAX : release_hold_time_in;
    assign app_hold = (apply_hold_time_in > hoist_brake_pkg::HOLD_MAX) ?
                      hoist_brake_pkg::HOLD_MAX : apply_hold_time_in;

    // Cross-multiply so no divider is needed
    // R2: percent of basis
    assign cur_scaled = hoist_brake_pkg::PROD_W'(output_current_in) * hoist_brake_pkg::PERCENT_SCALE;
    assign thr_scaled = hoist_brake_pkg::PROD_W'(pct_clamped) * hoist_brake_pkg::PROD_W'(basis);
    assign cur_over = (cur_scaled > thr_scaled);
    assign freq_over = (output_frequency_in > rel_freq_thr);
    assign freq_low = (output_frequency_in < app_freq_thr);

    // ------------------------------------------------------------
    // Hold timers
    // ------------------------------------------------------------
    hoist_brake_pkg::brake_state_t state;       // Present brake state
    hoist_brake_pkg::brake_state_t next_state;  // Following brake state
    logic release_qual;                         // Torque proven this cycle
    logic apply_qual;                           // Stop proven this cycle
    logic release_done;                         // Torque held long enough
    logic apply_done;                           // Stop held long enough

    // R1: either current or frequency proves torque
    assign release_qual = (state == hoist_brake_pkg::BRAKE_APPLIED) && !forced && (cur_over || freq_over);
    // R3: run off and frequency low
    assign apply_qual = (state == hoist_brake_pkg::BRAKE_RELEASED) && !forced && !run_on && freq_low;

    // Release side timer
    brake_hold_timer #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_release_timer (
        .sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .qual_in(release_qual),
        .hold_in(rel_hold),
        .done_out(release_done)
    );

    // Apply side timer
    brake_hold_timer #(
        .STEP_CYCLES(STEP_CYCLES)
    ) u_apply_timer (
        .sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .qual_in(apply_qual),
        .hold_in(app_hold),
        .done_out(apply_done)
    );

    // ------------------------------------------------------------
    // Brake state decision
    // ------------------------------------------------------------
    // Shutdown and motor 2 override the timers outright
    always_comb begin
        next_state = state;
        if (forced) begin
            // R5: shutdown releases at once
            // R4: motor 2 holds release
            next_state = hoist_brake_pkg::BRAKE_RELEASED;
        end else if (release_done) begin
            // R1: torque proven
            next_state = hoist_brake_pkg::BRAKE_RELEASED;
        end else if (apply_done) begin
            // R3: stop proven
            next_state = hoist_brake_pkg::BRAKE_APPLIED;
        end
    end

    // Brake starts applied, the safe state for a hoist
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state <= hoist_brake_pkg::BRAKE_APPLIED;
        end else begin
            state <= next_state;
        end
    end

    // R6: high means release
    assign brake_release_output_out = (state == hoist_brake_pkg::BRAKE_RELEASED);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_RELEASE_ON_HOLD: // R1
        assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
            release_done |=> brake_release_output_out)
        else $error("brake not released after torque hold");

    AST_BASIS_RATED: // R2
        assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
            !low_voltage_variant_in && (pct_clamped == hoist_brake_pkg::PCT_MAX)
            && (hoist_brake_pkg::PROD_W'(output_current_in) > (hoist_brake_pkg::PROD_W'(rated_current_in) << 1))
            |-> cur_over)
        else $error("current threshold not scaled by rated current");

    AST_APPLY_ON_HOLD: // R3
        assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
            apply_done && !release_done |=> !brake_release_output_out)
        else $error("brake not applied after stop hold");

    AST_NO_APPLY_WHILE_RUN: // R3
        assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
            $fell(brake_release_output_out) |-> !$past(run_on) && !$past(forced))
        else $error("brake applied with run command on");

    AST_MOTOR2_HOLDS: // R4
        assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
            motor2_sel ##1 motor2_sel |-> brake_release_output_out)
        else $error("brake applied while second motor selected");

    AST_SHUTDOWN_IMMEDIATE: // R5
        assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
            $rose(alarm_shutdown_in) ##1 alarm_shutdown_in ##1 alarm_shutdown_in
            |=> brake_release_output_out)
        else $error("shutdown did not change brake output within three cycles");

    AST_RISE_HAS_CAUSE: // R6
        assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
            $rose(brake_release_output_out) |-> $past(release_done) || $past(forced))
        else $error("brake released without cause");

endmodule

// file: brake_actuator_model.sv
/*
 * Behavioural model of the mechanical brake of a hoisting machine.
 * Assumes the command comes from the brake control on the same clock.
 */
module brake_actuator_model (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic release_cmd_in, // High asks for release
    output logic released_out        // High while the shoe is lifted
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Shoe movement
    // ------------------------------------------------------------
    // high releases, low applies
    // One cycle of mechanical lag, so a glitch on the command still shows
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            released_out <= 1'b0; // Spring holds the brake applied
        end else begin
            released_out <= release_cmd_in;
        end
    end
endmodule

// file: hoist_brake_signal_control_test.sv
/*
 * Self-checking bench for the hoist brake signal control.
 * Assumes the design is built with a short hold step of 4 cycles.
 */
module hoist_brake_signal_control_test;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam int S = 4; // Cycles per hold step
    typedef struct {
        logic [15:0] cur, freq, rated;
        logic lv;
        logic [1:0] model;
        logic [7:0] pct;
        logic [15:0] fthr;
        logic [5:0] hold;
        logic exp;
    } row_t;
    row_t rows [14];
    logic sys_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [15:0] cur = 16'h0000, freq = 16'h0000, rated = 16'h0064, fthr = 16'h00fa, athr = 16'h0000;
    logic lv = 1'b0, run = 1'b1, motor2 = 1'b0, coast = 1'b0, alarm = 1'b0;
    logic [1:0] model = 2'h0;
    logic [7:0] pct = 8'hc8;
    logic [5:0] rhold = 6'h02, ahold = 6'h02;
    logic brake_out, shoe;
    int num_errors = 0;
    int samples_checked = 0;

    always #12.5 sys_clk_in = ~sys_clk_in; // 40 MHz

    hoist_brake_signal_control #(.STEP_CYCLES(S)) i_dut (
        .sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
        .output_current_in(cur), .output_frequency_in(freq), .rated_current_in(rated),
        .low_voltage_variant_in(lv), .model_index_in(model),
        .release_current_threshold_in(pct), .release_frequency_threshold_in(fthr),
        .release_hold_time_in(rhold), .apply_frequency_threshold_in(athr),
        .apply_hold_time_in(ahold), .run_command_in(run), .second_motor_select_in(motor2),
        .coast_stop_command_in(coast), .alarm_shutdown_in(alarm),
        .brake_release_output_out(brake_out)
    );
    brake_actuator_model i_brake (
        .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .release_cmd_in(brake_out), .released_out(shoe)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask

    // Compare one bit, counted either way
    task automatic check_bit(input string what, input logic exp, input logic seen);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %b seen %b", what, exp, seen);
        end
    endtask

    // Output and shoe sampled mid-cycle, away from the launching edge
    task automatic expect_brake(input logic exp);
        @(negedge sys_clk_in);
        check_bit("brake_release_output_out", exp, brake_out);
        check_bit("actuator released", exp, shoe);
    endtask

    task automatic finish_test();
        $display("errors %0d, comparisons %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    // Rows plus hand tests stay well under 6000 cycles
    initial begin
        tick(20000);
        num_errors++;
        finish_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        // Current rows: strict compare against percent of basis
        rows[0] = '{16'h0033, 16'h0000, 16'h0064, 1'b0, 2'h0, 8'h32, 16'h00fa, 6'h02, 1'b1};
        rows[1] = '{16'h0032, 16'h0000, 16'h0064, 1'b0, 2'h0, 8'h32, 16'h00fa, 6'h02, 1'b0};
        rows[2] = '{16'h001f, 16'h0000, 16'h0064, 1'b1, 2'h2, 8'h64, 16'h00fa, 6'h02, 1'b1};
        rows[3] = '{16'h001e, 16'h0000, 16'h0064, 1'b1, 2'h2, 8'h64, 16'h00fa, 6'h02, 1'b0};
        rows[4] = '{16'h0011, 16'h0000, 16'h0064, 1'b1, 2'h0, 8'hc8, 16'h00fa, 6'h01, 1'b1};
        rows[5] = '{16'h0010, 16'h0000, 16'h0064, 1'b1, 2'h0, 8'hc8, 16'h00fa, 6'h01, 1'b0};
        rows[6] = '{16'h0004, 16'h0000, 16'h0064, 1'b1, 2'h1, 8'h14, 16'h00fa, 6'h02, 1'b1};
        rows[7] = '{16'h0006, 16'h0000, 16'h0064, 1'b1, 2'h3, 8'h0a, 16'h00fa, 6'h02, 1'b1};
        rows[8] = '{16'h0005, 16'h0000, 16'h0064, 1'b1, 2'h3, 8'h0a, 16'h00fa, 6'h02, 1'b0};
        // Frequency rows, the last with zero hold, then a current row with the longest hold
        rows[9] = '{16'h0000, 16'h00fb, 16'h0064, 1'b0, 2'h0, 8'hc8, 16'h00fa, 6'h03, 1'b1};
        rows[10] = '{16'h0000, 16'h00fa, 16'h0064, 1'b0, 2'h0, 8'hc8, 16'h00fa, 6'h03, 1'b0};
        rows[11] = '{16'h0000, 16'h000b, 16'h0064, 1'b0, 2'h0, 8'hc8, 16'h000a, 6'h00, 1'b1};
        rows[12] = '{16'h0033, 16'h0000, 16'h0064, 1'b0, 2'h0, 8'h32, 16'h00fa, 6'h32, 1'b1};
        // Threshold above 200 percent clamps, so just over twice rated releases
        rows[13] = '{16'h00c9, 16'h0000, 16'h0064, 1'b0, 2'h0, 8'hff, 16'h00fa, 6'h01, 1'b1};
        tick(12);
        resetn_in <= 1'b1;
        foreach (rows[i]) begin
            // Settings change under reset with measurements at zero, so no
            // qualification leaks into the reset cycles or across rows
            tick(1);
            resetn_in <= 1'b0;
            {cur, freq} <= {16'h0000, 16'h0000};
            {rated, lv, model} <= {rows[i].rated, rows[i].lv, rows[i].model};
            {pct, fthr, rhold} <= {rows[i].pct, rows[i].fthr, rows[i].hold};
            expect_brake(1'b0); // RESET
            // Two edges in reset, so the release edge sees no stale state
            tick(2);
            resetn_in <= 1'b1;
            {cur, freq} <= {rows[i].cur, rows[i].freq};
            if (rows[i].hold != 6'h00) begin
                // Edge where the hold completes, one before the output rises
                tick(int'(rows[i].hold) * S);
                expect_brake(1'b0);
            end
            tick(6);
            expect_brake(rows[i].exp);
        end
        // Run still on: low frequency alone never applies
        tick(1);
        {cur, freq, athr, ahold} <= {16'h0000, 16'h000a, 16'h0014, 6'h02};
        tick(20);
        expect_brake(1'b1);
        tick(1);
        run <= 1'b0;
        tick(2 * S - 1);
        expect_brake(1'b1);
        tick(9);
        expect_brake(1'b0);
        // Release qualification broken for one cycle restarts the count
        tick(1);
        {run, freq, fthr, rhold} <= {1'b1, 16'h000b, 16'h000a, 6'h02};
        tick(6);
        freq <= 16'h0005;
        tick(1);
        freq <= 16'h000b;
        tick(2 * S - 1);
        expect_brake(1'b0);
        tick(6);
        expect_brake(1'b1);
        // Apply threshold is strict: equal frequency keeps release
        tick(1);
        {run, freq} <= {1'b0, 16'h0014};
        tick(20);
        expect_brake(1'b1);
        tick(1);
        freq <= 16'h0013;
        tick(16);
        expect_brake(1'b0);
        // Second motor holds release despite apply conditions
        tick(1);
        {freq, motor2} <= {16'h0000, 1'b1};
        tick(5);
        expect_brake(1'b1);
        tick(20);
        expect_brake(1'b1);
        tick(1);
        motor2 <= 1'b0;
        tick(2 * S - 1);
        expect_brake(1'b1);
        tick(9);
        expect_brake(1'b0);
        // Alarm then coast stop: no timer between pin and output
        for (int k = 0; k < 2; k++) begin
            tick(1);
            {rhold, ahold} <= {6'h32, 6'h32};
            if (k == 0) alarm <= 1'b1;
            else coast <= 1'b1;
            tick(5);
            expect_brake(1'b1);
            tick(1);
            {alarm, coast} <= 2'b00;
            tick(5);
            expect_brake(1'b1);
            tick(210);
            expect_brake(1'b0);
        end
        finish_test();
    end
endmodule
